// ---- verilog/erq_pkg.sv ----
// Functional notes
// R1: queue holds at most twenty error records, captured as errors are detected.
// R2: one beep pulse per new error, whether or not it is stored.
// R3: records come out oldest first.
// R4: error indicator is on while any record is queued, off when empty.
// R5: error with twenty held overwrites the newest record with the overflow code.
// R6: after overflow further errors are dropped until a record is read out.
// R7: empty remote read gives +0 no-error text; empty panel read gives no-errors text.
// R8: power-up reset and clear-status empty the whole queue.
// R9: the reset command leaves queue and indicator untouched.
// R10: each panel key press pops and shows one record until empty.
// R11: each remote query pops and returns exactly one record from the head.
// R12: record goes out as signed code, comma, quoted text of at most eighty characters.
// R13: overflow record follows the nineteen older ones and pops like any other.
package erq_pkg;
    localparam int QDEPTH = 20;
    localparam int CODE_W = 16;
    localparam int NDIG = 5;
    localparam logic [4:0] PTR_LAST = 5'h13;
    localparam logic [4:0] PTR_ZERO = 5'h00;
    localparam logic [4:0] PTR_ONE = 5'h01;
    localparam logic [4:0] CNT_FULL = 5'h14;
    localparam logic signed [15:0] CODE_OVF = 16'shfea2;
    localparam logic signed [15:0] CODE_NONE = 16'sh0000;
    localparam logic signed [15:0] CODE_UNDEF = 16'shff8f;
    localparam logic [16:0] DEC_BASE = 17'h0000a;
    localparam logic [6:0] TXT_MAX = 7'h50;
    localparam logic [6:0] LEN_OVF = 7'h0f;
    localparam logic [6:0] LEN_NONE = 7'h08;
    localparam logic [6:0] LEN_PANEL = 7'h09;
    localparam logic [6:0] LEN_UNDEF = 7'h10;
    localparam logic [6:0] LEN_OTHER = 7'h05;
    localparam logic [7:0] CH_PLUS = 8'h2b;
    localparam logic [7:0] CH_MINUS = 8'h2d;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_QUOTE = 8'h22;
    localparam logic [7:0] CH_ZERO = 8'h30;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_SIGN = 7'h02,
        ST_DIG = 7'h04,
        ST_COMMA = 7'h08,
        ST_QOPEN = 7'h10,
        ST_TEXT = 7'h20,
        ST_QCLOSE = 7'h40
    } erq_state_e;
endpackage

// ---- verilog/erq_bcd.sv ----
`timescale 1ns/1ps
`default_nettype none
module erq_bcd
    import erq_pkg::*;
(
    input wire logic signed [15:0] code_i,
    output logic [NDIG*4-1:0] dig_o
);
    logic [16:0] q [0:NDIG];
    logic [16:0] rem [0:NDIG-1];

    // 17 bits so the most negative code still has a magnitude
    assign q[0] = code_i[15] ? 17'(-{code_i[15], code_i}) : 17'({1'b0, code_i});

    genvar i;
    generate
        for (i = 0; i < NDIG; i++) begin : g_dig
            assign q[i+1] = q[i] / DEC_BASE;
            assign rem[i] = q[i] % DEC_BASE;
            assign dig_o[4*i +: 4] = rem[i][3:0];
        end
    endgenerate
endmodule
`default_nettype wire

// ---- verilog/erq_txt.sv ----
`timescale 1ns/1ps
`default_nettype none
module erq_txt
    import erq_pkg::*;
(
    input wire logic signed [15:0] code_i,
    input wire logic bare_i,
    input wire logic [6:0] idx_i,
    output logic [7:0] chr_o,
    output logic [6:0] len_o
);
    localparam logic [127:0] TXT_OVF = "Too many errors";
    localparam logic [127:0] TXT_NONE = "No error";
    localparam logic [127:0] TXT_PANEL = "NO ERRORS";
    localparam logic [127:0] TXT_UNDEF = "Undefined header";
    localparam logic [127:0] TXT_OTHER = "Error";

    logic [127:0] str;
    logic [6:0] sh;

    always_comb begin
        if (bare_i) begin
            str = TXT_PANEL;
            len_o = LEN_PANEL;
        end else if (code_i == CODE_OVF) begin
            str = TXT_OVF;
            len_o = LEN_OVF;
        end else if (code_i == CODE_NONE) begin
            str = TXT_NONE;
            len_o = LEN_NONE;
        end else if (code_i == CODE_UNDEF) begin
            str = TXT_UNDEF;
            len_o = LEN_UNDEF;
        end else begin
            str = TXT_OTHER;
            len_o = LEN_OTHER;
        end
        sh = 7'(len_o - 7'h01 - idx_i);
        chr_o = str[{sh[3:0], 3'b000} +: 8];
    end
endmodule
`default_nettype wire

// ---- verilog/erq_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module erq_top
    import erq_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic err_valid_i,
    input wire logic signed [15:0] err_code_i,
    input wire logic cls_i,
    input wire logic rst_cmd_i,
    input wire logic key_i,
    input wire logic query_i,
    input wire logic chr_ready_i,
    output logic err_ind_o,
    output logic beep_o,
    output logic ovf_o,
    output logic [4:0] count_o,
    output logic busy_o,
    output logic chr_valid_o,
    output logic [7:0] chr_o,
    output logic chr_last_o
);
    // ************************************************
    // queue storage
    // ************************************************
    logic signed [15:0] mem [0:QDEPTH-1];
    logic [4:0] rd_r, rd_nxt, wr_r, wr_nxt, cnt_r, cnt_nxt;
    logic ovf_r, ovf_nxt, beep_r, beep_nxt;
    logic we;
    logic [4:0] waddr;
    logic signed [15:0] wdata;
    logic [4:0] cnt_left;
    logic ovf_left;
    logic accept, pop;

    function automatic logic [4:0] ptr_inc(input logic [4:0] p);
        ptr_inc = (p == PTR_LAST) ? PTR_ZERO : 5'(p + PTR_ONE);
    endfunction

    function automatic logic [4:0] ptr_dec(input logic [4:0] p);
        ptr_dec = (p == PTR_ZERO) ? PTR_LAST : 5'(p - PTR_ONE);
    endfunction

    always_comb begin
        rd_nxt = rd_r;
        wr_nxt = wr_r;
        cnt_nxt = cnt_r;
        ovf_nxt = ovf_r;
        we = 1'b0;
        waddr = wr_r;
        wdata = err_code_i;
        // defaults keep the clear branch free of latches
        cnt_left = cnt_r;
        ovf_left = ovf_r;
        beep_nxt = err_valid_i; // [R2]
        // rst_cmd_i deliberately has no effect here [R9]
        if (cls_i) begin
            // clear empties, but an error in the same cycle still lands [R8]
            rd_nxt = PTR_ZERO;
            wr_nxt = PTR_ZERO;
            cnt_nxt = PTR_ZERO;
            ovf_nxt = 1'b0;
            if (err_valid_i) begin
                we = 1'b1;
                waddr = PTR_ZERO;
                wr_nxt = PTR_ONE;
                cnt_nxt = PTR_ONE;
            end
        end else begin
            cnt_left = pop ? 5'(cnt_r - PTR_ONE) : cnt_r;
            ovf_left = ovf_r & ~pop; // [R6]
            if (pop) begin
                rd_nxt = ptr_inc(rd_r); // [R3] [R13]
            end
            cnt_nxt = cnt_left;
            ovf_nxt = ovf_left;
            if (err_valid_i) begin
                if (cnt_left != CNT_FULL) begin
                    we = 1'b1; // [R1]
                    wr_nxt = ptr_inc(wr_r);
                    cnt_nxt = 5'(cnt_left + PTR_ONE);
                end else if (!ovf_left) begin
                    we = 1'b1; // [R5]
                    waddr = ptr_dec(wr_r);
                    wdata = CODE_OVF;
                    ovf_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rd_r <= PTR_ZERO; // [R8]
            wr_r <= PTR_ZERO;
            cnt_r <= PTR_ZERO;
            ovf_r <= 1'b0;
            beep_r <= 1'b0;
        end else begin
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            cnt_r <= cnt_nxt;
            ovf_r <= ovf_nxt;
            beep_r <= beep_nxt;
        end
    end

    // no reset on the array: slots are only read behind a nonzero count
    always_ff @(posedge clk_i) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign err_ind_o = (cnt_r != PTR_ZERO); // [R4]
    assign beep_o = beep_r;
    assign ovf_o = ovf_r;
    assign count_o = cnt_r;

    // ************************************************
    // record formatter
    // ************************************************
    erq_state_e st_r, st_nxt;
    logic signed [15:0] code_r, code_nxt;
    logic bare_r, bare_nxt;
    logic [2:0] dig_r, dig_nxt, top;
    logic [6:0] tidx_r, tidx_nxt;
    logic vld_r, vld_nxt, last_r, last_nxt;
    logic [7:0] chr_r, chr_nxt;
    logic [NDIG*4-1:0] digs;
    logic [7:0] txt_chr;
    logic [6:0] txt_len;
    logic step;

    erq_bcd u_bcd (
        .code_i(code_r),
        .dig_o(digs)
    );

    erq_txt u_txt (
        .code_i(code_r),
        .bare_i(bare_r),
        .idx_i(tidx_r),
        .chr_o(txt_chr),
        .len_o(txt_len)
    );

    always_comb begin
        top = 3'h0;
        for (int k = 1; k < NDIG; k++) begin
            if (digs[4*k +: 4] != 4'h0) begin
                top = 3'(k);
            end
        end
    end

    // one request per finished answer; requests while busy are dropped
    assign busy_o = (st_r != ST_IDLE) | vld_r;
    assign accept = ~busy_o & (key_i | query_i);
    assign pop = accept & (cnt_r != PTR_ZERO); // [R10] [R11]
    assign step = (st_r != ST_IDLE) & (~vld_r | chr_ready_i);

    always_comb begin
        st_nxt = st_r;
        code_nxt = code_r;
        bare_nxt = bare_r;
        dig_nxt = dig_r;
        tidx_nxt = tidx_r;
        vld_nxt = vld_r & ~chr_ready_i;
        last_nxt = last_r;
        chr_nxt = chr_r;
        if (accept) begin
            code_nxt = pop ? mem[rd_r] : CODE_NONE; // [R3] [R7]
            bare_nxt = ~query_i & ~pop; // [R7]
            tidx_nxt = 7'h00;
            st_nxt = (~query_i & ~pop) ? ST_TEXT : ST_SIGN;
        end
        if (step) begin
            vld_nxt = 1'b1;
            last_nxt = 1'b0;
            case (st_r)
                ST_SIGN: begin
                    chr_nxt = code_r[15] ? CH_MINUS : CH_PLUS; // [R12]
                    dig_nxt = top;
                    st_nxt = ST_DIG;
                end
                ST_DIG: begin
                    chr_nxt = CH_ZERO | {4'h0, digs[{dig_r, 2'b00} +: 4]};
                    dig_nxt = 3'(dig_r - 3'h1);
                    st_nxt = (dig_r == 3'h0) ? ST_COMMA : ST_DIG;
                end
                ST_COMMA: begin
                    chr_nxt = CH_COMMA; // [R12]
                    st_nxt = ST_QOPEN;
                end
                ST_QOPEN: begin
                    chr_nxt = CH_QUOTE;
                    tidx_nxt = 7'h00;
                    st_nxt = ST_TEXT;
                end
                ST_TEXT: begin
                    chr_nxt = txt_chr;
                    tidx_nxt = 7'(tidx_r + 7'h01);
                    if (tidx_r == 7'(txt_len - 7'h01)) begin
                        last_nxt = bare_r;
                        st_nxt = bare_r ? ST_IDLE : ST_QCLOSE;
                    end
                end
                ST_QCLOSE: begin
                    chr_nxt = CH_QUOTE;
                    last_nxt = 1'b1;
                    st_nxt = ST_IDLE;
                end
                default: begin
                    st_nxt = ST_IDLE;
                    vld_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_r <= ST_IDLE;
            code_r <= CODE_NONE;
            bare_r <= 1'b0;
            dig_r <= 3'h0;
            tidx_r <= 7'h00;
            vld_r <= 1'b0;
            last_r <= 1'b0;
            chr_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            code_r <= code_nxt;
            bare_r <= bare_nxt;
            dig_r <= dig_nxt;
            tidx_r <= tidx_nxt;
            vld_r <= vld_nxt;
            last_r <= last_nxt;
            chr_r <= chr_nxt;
        end
    end

    assign chr_valid_o = vld_r;
    assign chr_o = chr_r;
    assign chr_last_o = last_r & vld_r;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    cnt_bound_a: assert property (cnt_r <= CNT_FULL) // [R1]
        else $error("queue count above twenty");
    beep_once_a: assert property (err_valid_i |=> beep_o ##1 (beep_o == $past(err_valid_i))) // [R2]
        else $error("beep does not follow error");
    ind_level_a: assert property (err_ind_o == (cnt_r != PTR_ZERO) // [R4]
        && (err_ind_o || (rd_r == wr_r && !ovf_r)))
        else $error("indicator disagrees with queue state");
    ovf_take_a: assert property ((err_valid_i && !cls_i && !pop && cnt_r == CNT_FULL && !ovf_r) // [R5]
        |=> ovf_r && mem[ptr_dec(wr_r)] == CODE_OVF && cnt_r == CNT_FULL)
        else $error("overflow code not placed in newest slot");
    ovf_drop_a: assert property ((ovf_r && err_valid_i && !cls_i && !pop) |=> $stable(cnt_r) && $stable(wr_r)) // [R6]
        else $error("error stored while overflowed");
    cls_empty_a: assert property ((cls_i && !err_valid_i) |=> cnt_r == PTR_ZERO && !err_ind_o) // [R8]
        else $error("clear status left records");
    rst_keep_a: assert property ((rst_cmd_i && !cls_i && !err_valid_i && !pop) // [R9]
        |=> $stable(cnt_r) && $stable(err_ind_o))
        else $error("reset command touched queue");
    pop_one_a: assert property ((pop && !err_valid_i && !cls_i) |=> cnt_r == 5'($past(cnt_r) - PTR_ONE)) // [R10] [R11]
        else $error("pop did not remove one record");
    empty_rsp_a: assert property ((accept && query_i && cnt_r == PTR_ZERO) // [R7]
        |=> ##1 chr_valid_o && chr_o == CH_PLUS)
        else $error("empty query did not start with plus");
    txt_len_a: assert property ((st_r == ST_TEXT) |-> tidx_r < txt_len && txt_len <= TXT_MAX) // [R12]
        else $error("text index past its length or text longer than eighty");
    fifo_head_a: assert property ((pop && cnt_r == PTR_ONE && !err_valid_i && !cls_i) |=> !err_ind_o) // [R13]
        else $error("last record pop left queue nonempty");

    // ************************************************
    // queue state and answer stream checks
    // ************************************************
    ovf_full_a: assert property (ovf_r |-> cnt_r == CNT_FULL) // [R5]
        else $error("overflow flag set below twenty records");
    full_keep_a: assert property ((cnt_r == CNT_FULL && !pop && !cls_i) |=> cnt_r == CNT_FULL) // [R5]
        else $error("full queue lost a record without a read");
    ptr_range_a: assert property (rd_r <= PTR_LAST && wr_r <= PTR_LAST) // [R1]
        else $error("queue pointer outside twenty slots");
    pop_ovf_a: assert property ((pop && ovf_r && !cls_i) |=> !ovf_r) // [R6] [R13]
        else $error("read did not reopen the queue after overflow");
    beep_drop_a: assert property ((err_valid_i && ovf_r && !pop && !cls_i) |=> beep_o) // [R2]
        else $error("dropped error gave no beep");
    busy_drop_a: assert property ((busy_o && (key_i || query_i) && !err_valid_i && !cls_i) // [R11]
        |=> $stable(cnt_r))
        else $error("request taken while busy");
    ans_start_a: assert property (accept |=> busy_o ##1 chr_valid_o) // [R10] [R11]
        else $error("answer did not start two cycles after request");
    sign_first_a: assert property ((accept && pop) // [R12]
        |=> ##1 chr_valid_o && (chr_o == CH_PLUS || chr_o == CH_MINUS))
        else $error("record answer does not start with a sign");
    chr_hold_a: assert property ((chr_valid_o && !chr_ready_i) // [R11]
        |=> chr_valid_o && $stable(chr_o) && $stable(chr_last_o))
        else $error("character changed before it was taken");
    close_quote_a: assert property ((chr_valid_o && chr_last_o && !bare_r) |-> chr_o == CH_QUOTE) // [R12]
        else $error("quoted answer does not end in a quote");
    last_free_a: assert property ((chr_valid_o && chr_last_o && chr_ready_i) |=> !busy_o) // [R11]
        else $error("formatter still busy after final character");
endmodule
`default_nettype wire

// ---- verif/erq_reader.sv ----
`timescale 1ns/1ps
`default_nettype none
module erq_reader (
    input wire logic clk_i,
    input wire logic chr_valid_i,
    input wire logic chr_last_i,
    output logic chr_ready_o,
    output logic [7:0] ans_o
);
    initial chr_ready_o = 1'b0;
    initial ans_o = 8'h00;
    // random stalls so every character must hold until taken
    always @(posedge clk_i) begin
        chr_ready_o <= ($urandom % 3) != 0;
        if (chr_valid_i && chr_ready_o && chr_last_i) begin
            ans_o <= ans_o + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ---- verif/tb_erq_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_erq_top;
    import erq_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic err_valid_i = 1'b0;
    logic signed [15:0] err_code_i = 16'sh0000;
    logic cls_i = 1'b0;
    logic rst_cmd_i = 1'b0;
    logic key_i = 1'b0;
    logic query_i = 1'b0;
    logic chr_ready_i;
    logic err_ind_o, beep_o, ovf_o, busy_o, chr_valid_o, chr_last_o;
    logic [4:0] count_o;
    logic [7:0] chr_o, ans;
    logic signed [15:0] mq[$];
    logic [8:0] eq[$];
    logic movf = 1'b0;
    int fails = 0;
    int check_count = 0;
    int beeps = 0;
    int errs = 0;
    int rds = 0;
    int cyc = 0;

    always #10 clk_i = ~clk_i;

    erq_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .err_valid_i(err_valid_i), .err_code_i(err_code_i),
        .cls_i(cls_i), .rst_cmd_i(rst_cmd_i), .key_i(key_i), .query_i(query_i),
        .chr_ready_i(chr_ready_i), .err_ind_o(err_ind_o), .beep_o(beep_o), .ovf_o(ovf_o),
        .count_o(count_o), .busy_o(busy_o), .chr_valid_o(chr_valid_o), .chr_o(chr_o),
        .chr_last_o(chr_last_o));

    erq_reader reader (.clk_i(clk_i), .chr_valid_i(chr_valid_o), .chr_last_i(chr_last_o),
        .chr_ready_o(chr_ready_i), .ans_o(ans));

    // ****************************************
    // checking
    // ****************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic string txt(input logic signed [15:0] c);
        if (c == CODE_OVF) return "Too many errors";
        if (c == CODE_NONE) return "No error";
        if (c == CODE_UNDEF) return "Undefined header";
        return "Error";
    endfunction

    // watcher: oldest noted character against each one taken
    always @(posedge clk_i) begin
        cyc++;
        if (beep_o === 1'b1) beeps++;
        if (chr_valid_o === 1'b1 && chr_ready_i === 1'b1) begin
            if (eq.size() == 0) chk({7'h0, chr_last_o, chr_o}, 16'hffff);
            else chk({7'h0, chr_last_o, chr_o}, {7'h0, eq.pop_front()});
        end
        if (cyc > 20000) begin
            fails++;
            report_and_stop();
        end
    end

    // ****************************************
    // drivers
    // ****************************************
    task automatic status();
        chk({11'h0, count_o}, 16'(mq.size()));
        chk({14'h0, ovf_o, err_ind_o}, {14'h0, movf, mq.size() != 0});
    endtask

    task automatic send_err(input int n, input logic signed [15:0] c0);
        logic signed [15:0] c;
        for (int i = 0; i < n; i++) begin
            c = (i == 0) ? c0 : 16'($urandom);
            @(posedge clk_i);
            err_valid_i <= 1'b1;
            err_code_i <= c;
            errs++;
            if (movf) begin
            end else if (mq.size() == QDEPTH) begin
                mq[QDEPTH-1] = CODE_OVF;
                movf = 1'b1;
            end else begin
                mq.push_back(c);
            end
        end
        @(posedge clk_i);
        err_valid_i <= 1'b0;
        @(posedge clk_i);
        #1;
        status();
        chk(16'(beeps), 16'(errs));
    endtask

    task automatic rd(input logic k);
        string s;
        logic signed [15:0] c;
        if (mq.size() == 0) begin
            s = k ? "NO ERRORS" : "+0,\"No error\"";
        end else begin
            c = mq.pop_front();
            movf = 1'b0;
            s = $sformatf("%s%0d,\"%s\"", c < 0 ? "-" : "+", c < 0 ? -int'(c) : int'(c), txt(c));
        end
        for (int n = 0; n < s.len(); n++) eq.push_back({n == s.len() - 1, s[n]});
        rds++;
        @(posedge clk_i);
        key_i <= k;
        query_i <= !k;
        // second edge falls while busy, so it must be ignored
        repeat (2) @(posedge clk_i);
        key_i <= 1'b0;
        query_i <= 1'b0;
        #1;
        while (busy_o !== 1'b0) begin
            @(posedge clk_i);
            #1;
        end
        status();
    endtask

    task automatic pulse(input int w);
        @(posedge clk_i);
        cls_i <= (w == 0);
        rst_cmd_i <= (w == 1);
        nrst_i <= (w != 2);
        @(posedge clk_i);
        cls_i <= 1'b0;
        rst_cmd_i <= 1'b0;
        nrst_i <= 1'b1;
        #1;
        if (w != 1) begin
            mq.delete();
            movf = 1'b0;
        end
        status();
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        void'($urandom(32'hc32d008e));
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        #1;
        status();
        rd(1'b1);
        rd(1'b0);
        send_err(3, CODE_UNDEF);
        rd(1'b1);
        rd(1'b0);
        rd(1'b0);
        rd(1'b0);
        send_err(22, CODE_NONE);
        pulse(1);
        repeat (20) rd(1'($urandom));
        rd(1'b1);
        send_err(2, CODE_OVF);
        pulse(0);
        send_err(1, CODE_UNDEF);
        pulse(2);
        repeat (4) @(posedge clk_i);
        chk({8'h0, ans}, 16'(rds));
        report_and_stop();
    end
endmodule
`default_nettype wire
